// >>> hw/microstep_pkg.sv
// Shared constants and types of the micro-step sequencer and chopper
package microstep_pkg;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 125;
   localparam int DEAD_NS = 300;
   localparam int DEAD_CYC = (DEAD_NS * CLK_MHZ + 999) / 1000;
   localparam int BLANK_NS = 4000;
   localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
   localparam int SENSE_NS = 200;
   localparam int SENSE_CYC = (SENSE_NS * CLK_MHZ + 999) / 1000;
   localparam int OSC_DIV = 100;
   localparam logic [2:0] SLOT_LAST = 3'h7;
   localparam logic [2:0] SLOT_PRE_FAST = 3'h6;

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   localparam logic [5:0] POS_HOME = 6'h00;
   localparam logic [5:0] POS_QUARTER = 6'h10;
   localparam logic [5:0] POS_THREE_Q = 6'h30;
   localparam logic [4:0] HALF_STEPS = 5'h10;
   localparam logic [1:0] MODE_4W12 = 2'h0;
   localparam logic [1:0] MODE_12 = 2'h1;
   localparam logic [1:0] MODE_W12 = 2'h2;
   localparam logic [5:0] STRIDE_4W12 = 6'h01;
   localparam logic [5:0] STRIDE_2W12 = 6'h02;
   localparam logic [5:0] STRIDE_W12 = 6'h04;
   localparam logic [5:0] STRIDE_12 = 6'h08;
   localparam logic [6:0] LEVEL_ZERO = 7'h00;

   // ---------------------------------------------------------------
   // Bridge patterns {high_left, high_right, low_left, low_right}
   // ---------------------------------------------------------------
   localparam logic [3:0] PAT_OFF = 4'h0;
   localparam logic [3:0] PAT_LEFT_HIGH = 4'h9;
   localparam logic [3:0] PAT_RIGHT_HIGH = 4'h6;
   localparam logic [3:0] PAT_SLOW = 4'h3;

   typedef enum logic [1:0] {DRV_OFF, DRV_CHARGE, DRV_SLOW, DRV_FAST} drive_e;

   // Quarter-cycle current magnitude in percent, index 0..16
   function automatic logic [6:0] quarter_level(input logic [4:0] idx);
      logic [6:0] lv;
      lv = 7'h00;
      case (idx)
         5'h00, 5'h01: lv = 7'd100;
         5'h02: lv = 7'd98;
         5'h03: lv = 7'd96;
         5'h04: lv = 7'd92;
         5'h05: lv = 7'd88;
         5'h06: lv = 7'd83;
         5'h07: lv = 7'd77;
         5'h08: lv = 7'd71;
         5'h09: lv = 7'd63;
         5'h0a: lv = 7'd56;
         5'h0b: lv = 7'd47;
         5'h0c: lv = 7'd38;
         5'h0d: lv = 7'd29;
         5'h0e: lv = 7'd20;
         5'h0f: lv = 7'd10;
         default: lv = 7'd0;
      endcase
      return lv;
   endfunction
endpackage

// >>> hw/bridge_dead_time.sv
// One H-bridge: switch pattern selection with dead time between patterns
`timescale 1ns/1ps
module bridge_dead_time #(
   parameter int DEAD = microstep_pkg::DEAD_CYC
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire microstep_pkg::drive_e drive,
   input wire logic reverse,
   output logic high_left,
   output logic high_right,
   output logic low_left,
   output logic low_right
);
   logic [3:0] gates_r;
   logic [5:0] dead_r;
   logic [3:0] target;
   logic [3:0] drop;
   logic [3:0] charge_pat;
   logic [3:0] fast_pat;

   // ---------------------------------------------------------------
   // Pattern selection
   // ---------------------------------------------------------------
   assign charge_pat = reverse ? microstep_pkg::PAT_RIGHT_HIGH : microstep_pkg::PAT_LEFT_HIGH;
   assign fast_pat = reverse ? microstep_pkg::PAT_LEFT_HIGH : microstep_pkg::PAT_RIGHT_HIGH;
   assign target = (drive == microstep_pkg::DRV_CHARGE) ? charge_pat :
                   (drive == microstep_pkg::DRV_FAST) ? fast_pat :
                   (drive == microstep_pkg::DRV_SLOW) ? microstep_pkg::PAT_SLOW :
                   microstep_pkg::PAT_OFF;
   assign drop = gates_r & ~target;

   // ---------------------------------------------------------------
   // Dead time: drop first, then wait, then switch on
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         // Reset counts as a drop: no switch on before a full dead interval
         gates_r <= 4'h0;
         dead_r <= 6'(DEAD - 1);
      end else if (drop != 4'h0) begin
         gates_r <= gates_r & target;
         dead_r <= 6'(DEAD - 1);
      end else if (dead_r != 6'h00) begin
         dead_r <= dead_r - 6'h01;
      end else begin
         gates_r <= target;
      end
   end

   assign high_left = gates_r[3];
   assign high_right = gates_r[2];
   assign low_left = gates_r[1];
   assign low_right = gates_r[0];

   // Helper: cycles since the last switch was dropped
   logic [5:0] since_drop_r;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         since_drop_r <= 6'h00;
      end else if (drop != 4'h0) begin
         since_drop_r <= 6'h00;
      end else if (since_drop_r != 6'h3f) begin
         since_drop_r <= since_drop_r + 6'h01;
      end
   end

   a_dead_gap: assert property (@(posedge clock) disable iff (!rst_n)
      (|(gates_r & ~$past(gates_r))) |-> ($past(since_drop_r) >= 6'(DEAD - 1)))
      else $error("switch turned on inside dead interval");
   a_no_shoot: assert property (@(posedge clock) disable iff (!rst_n)
      !(gates_r[3] && gates_r[1]) && !(gates_r[2] && gates_r[0]))
      else $error("both switches of one leg on");
endmodule // bridge_dead_time

// >>> hw/microstep_sequencer_chopper.sv
// Step/direction micro-step sequencer, mixed-decay chopper and over-current latch
`timescale 1ns/1ps
module microstep_sequencer_chopper #(
   parameter int OSC_DIV = microstep_pkg::OSC_DIV,
   parameter int BLANK_CYC = microstep_pkg::BLANK_CYC,
   parameter int DEAD_CYC = microstep_pkg::DEAD_CYC,
   parameter int SENSE_CYC = microstep_pkg::SENSE_CYC
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic step_pulse_in,
   input wire logic rotation_direction,
   input wire logic mode_select_1,
   input wire logic mode_select_2,
   input wire logic enable,
   input wire logic seq_reset_n,
   input wire logic sleep_input,
   input wire logic over_temp_trip,
   input wire logic [7:0] over_current_trip,
   input wire logic [1:0] supply_low_lock,
   input wire logic [1:0] current_reached_point,
   output logic [1:0] high_side_left,
   output logic [1:0] high_side_right,
   output logic [1:0] low_side_left,
   output logic [1:0] low_side_right,
   output logic [6:0] level_a,
   output logic [6:0] level_b,
   output logic reverse_a,
   output logic reverse_b,
   output logic home_flag_n_out,
   output logic home_flag_n_oe_n,
   output logic over_current_latched,
   output logic outputs_active
);
   // ---------------------------------------------------------------
   // Step position
   // ---------------------------------------------------------------
   logic step_prev_r;
   logic [1:0] mode_r;
   logic [5:0] pos_r;
   logic [1:0] mode_code;
   logic mode_change;
   logic step_rise;
   logic [5:0] stride;
   logic [5:0] pos_nxt;

   assign mode_code = {mode_select_2, mode_select_1};
   assign mode_change = mode_code != mode_r;
   assign step_rise = step_pulse_in && !step_prev_r;
   assign stride = (mode_code == microstep_pkg::MODE_4W12) ? microstep_pkg::STRIDE_4W12 :
                   (mode_code == microstep_pkg::MODE_12) ? microstep_pkg::STRIDE_12 :
                   (mode_code == microstep_pkg::MODE_W12) ? microstep_pkg::STRIDE_W12 :
                   microstep_pkg::STRIDE_2W12;
   assign pos_nxt = rotation_direction ? pos_r - stride : pos_r + stride;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         step_prev_r <= 1'b0;
         mode_r <= microstep_pkg::MODE_4W12;
         pos_r <= microstep_pkg::POS_HOME;
      end else begin
         mode_r <= mode_code;
         // Cleared under reset so a high step at release counts as an edge
         step_prev_r <= seq_reset_n ? step_pulse_in : 1'b0;
         if (!seq_reset_n || mode_change) begin
            pos_r <= microstep_pkg::POS_HOME;
         end else if (step_rise) begin
            pos_r <= pos_nxt;
         end
      end
   end

   // ---------------------------------------------------------------
   // Current table lookup over four quadrants
   // ---------------------------------------------------------------
   logic [5:0] pos_b;
   logic [4:0] idx_a;
   logic [4:0] idx_b;
   logic [4:0] fold_a;
   logic [4:0] fold_b;
   logic neg_a;
   logic neg_b;

   assign pos_b = pos_r - microstep_pkg::POS_QUARTER;
   assign idx_a = pos_r[4:0];
   assign idx_b = pos_b[4:0];
   assign fold_a = (idx_a > microstep_pkg::HALF_STEPS) ? 5'(6'd32 - {1'b0, idx_a}) : idx_a;
   assign fold_b = (idx_b > microstep_pkg::HALF_STEPS) ? 5'(6'd32 - {1'b0, idx_b}) : idx_b;
   assign neg_a = pos_r > microstep_pkg::POS_QUARTER && pos_r < microstep_pkg::POS_THREE_Q;
   assign neg_b = pos_b > microstep_pkg::POS_QUARTER && pos_b < microstep_pkg::POS_THREE_Q;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         level_a <= 7'd100;
         level_b <= microstep_pkg::LEVEL_ZERO;
         reverse_a <= 1'b0;
         reverse_b <= 1'b0;
      end else begin
         level_a <= microstep_pkg::quarter_level(fold_a);
         level_b <= microstep_pkg::quarter_level(fold_b);
         reverse_a <= neg_a;
         reverse_b <= neg_b;
      end
   end

   // Open drain home flag: drive low only at home
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         home_flag_n_oe_n <= 1'b0;
      end else begin
         home_flag_n_oe_n <= pos_r != microstep_pkg::POS_HOME;
      end
   end
   assign home_flag_n_out = 1'b0;

   // ---------------------------------------------------------------
   // Over-current blanking and latch
   // ---------------------------------------------------------------
   logic [7:0] oc_hit;
   logic enable_prev_r;
   logic low_prev_r;
   logic ocp_r;
   logic ocp_clear;
   logic supply_low;

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_blank
         logic [15:0] cnt_r;
         always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
               cnt_r <= 16'h0000;
            end else if (!over_current_trip[gi]) begin
               cnt_r <= 16'h0000;
            end else if (cnt_r != 16'(BLANK_CYC)) begin
               cnt_r <= cnt_r + 16'h0001;
            end
         end
         assign oc_hit[gi] = over_current_trip[gi] && cnt_r == 16'(BLANK_CYC - 1);
      end
   endgenerate

   assign supply_low = |supply_low_lock;
   assign ocp_clear = (enable && !enable_prev_r) || (supply_low && !low_prev_r);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         enable_prev_r <= 1'b0;
         low_prev_r <= 1'b0;
         ocp_r <= 1'b0;
      end else begin
         enable_prev_r <= enable;
         low_prev_r <= supply_low;
         if (|oc_hit) begin
            ocp_r <= 1'b1;
         end else if (ocp_clear) begin
            ocp_r <= 1'b0;
         end
      end
   end
   assign over_current_latched = ocp_r;

   // Every off condition keeps the counter running
   assign outputs_active = enable && sleep_input && !over_temp_trip && !supply_low && !ocp_r;

   // ---------------------------------------------------------------
   // Chop timebase and mixed decay
   // ---------------------------------------------------------------
   logic [15:0] div_r;
   logic [2:0] slot_r;
   logic tick;
   logic period_start;
   logic fast_start;

   assign tick = div_r == 16'(OSC_DIV - 1);
   assign period_start = tick && slot_r == microstep_pkg::SLOT_LAST;
   assign fast_start = tick && slot_r == microstep_pkg::SLOT_PRE_FAST;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         div_r <= 16'h0000;
         slot_r <= 3'h0;
      end else begin
         div_r <= tick ? 16'h0000 : div_r + 16'h0001;
         if (tick) begin
            slot_r <= slot_r + 3'h1;
         end
      end
   end

   generate
      for (gi = 0; gi < 2; gi++) begin : g_phase
         microstep_pkg::drive_e chop_r;
         microstep_pkg::drive_e drive;
         logic [7:0] sense_r;
         logic zero_level;

         assign zero_level = ((gi == 0) ? level_a : level_b) == microstep_pkg::LEVEL_ZERO;

         always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
               chop_r <= microstep_pkg::DRV_CHARGE;
               sense_r <= 8'h00;
            end else begin
               if (sense_r != 8'h00) begin
                  sense_r <= sense_r - 8'h01;
               end
               case (chop_r)
                  microstep_pkg::DRV_CHARGE: begin
                     if (fast_start) begin
                        chop_r <= microstep_pkg::DRV_FAST;
                     end else if (current_reached_point[gi] && sense_r == 8'h00) begin
                        chop_r <= microstep_pkg::DRV_SLOW;
                     end
                  end
                  microstep_pkg::DRV_SLOW: begin
                     if (fast_start) begin
                        chop_r <= microstep_pkg::DRV_FAST;
                     end
                  end
                  microstep_pkg::DRV_FAST: begin
                     if (period_start) begin
                        chop_r <= microstep_pkg::DRV_CHARGE;
                        // Sense window opens only once the dead time has passed
                        sense_r <= 8'(SENSE_CYC + DEAD_CYC);
                     end
                  end
                  default: chop_r <= microstep_pkg::DRV_CHARGE;
               endcase
            end
         end

         assign drive = !outputs_active ? microstep_pkg::DRV_OFF :
                        zero_level ? microstep_pkg::DRV_SLOW : chop_r;

         bridge_dead_time #(.DEAD(DEAD_CYC)) u_bridge (
            .clock(clock),
            .rst_n(rst_n),
            .drive(drive),
            .reverse((gi == 0) ? reverse_a : reverse_b),
            .high_left(high_side_left[gi]),
            .high_right(high_side_right[gi]),
            .low_left(low_side_left[gi]),
            .low_right(low_side_right[gi])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence s_fast_entry;
      fast_start ##1 (g_phase[0].chop_r == microstep_pkg::DRV_FAST);
   endsequence

   a_step_advance: assert property (
      (seq_reset_n && !mode_change && step_rise) |=> (pos_r == $past(pos_nxt)))
      else $error("position did not follow step edge");
   a_reset_home: assert property (
      !seq_reset_n |=> (pos_r == microstep_pkg::POS_HOME))
      else $error("reset did not return home");
   a_home_level: assert property (
      (pos_r == microstep_pkg::POS_HOME) |=> (level_a == 7'd100 && level_b == 7'd0))
      else $error("home levels wrong");
   a_home_flag: assert property (
      (pos_r == microstep_pkg::POS_HOME) |=> !home_flag_n_oe_n)
      else $error("home flag not driven at home");
   a_mode_restart: assert property (
      mode_change |=> (pos_r == microstep_pkg::POS_HOME))
      else $error("mode change did not restart");
   a_fast_slot: assert property (
      s_fast_entry |-> (slot_r == microstep_pkg::SLOT_LAST))
      else $error("fast decay outside last slot");
   a_period_len: assert property (
      period_start |=> !period_start [*8])
      else $error("chop period too short");
   a_ocp_hold: assert property (
      (ocp_r && !ocp_clear) |=> ocp_r && !outputs_active)
      else $error("over-current latch lost");
   a_outputs_off: assert property (
      (!enable || over_temp_trip || supply_low) |-> ##[1:3] (high_side_left == 2'b00 &&
         high_side_right == 2'b00 && low_side_left == 2'b00 && low_side_right == 2'b00))
      else $error("bridge still on while off");
endmodule // microstep_sequencer_chopper

// >>> sim/host_model.sv
// Host controller model: step, direction, mode, enable and sequencer reset
`timescale 1ns/1ps
module host_model #(
   parameter int EN_LOW_CYC = 18750
) (
   input wire logic clock,
   output logic step_pulse_in,
   output logic rotation_direction,
   output logic mode_select_1,
   output logic mode_select_2,
   output logic enable,
   output logic seq_reset_n
);
   initial begin
      step_pulse_in = 1'b0;
      rotation_direction = 1'b0;
      {mode_select_2, mode_select_1} = 2'h0;
      enable = 1'b0;
      seq_reset_n = 1'b0;
   end
   task automatic wait_n(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic set_reset(input logic v);
      wait_n(1);
      seq_reset_n = v;
      wait_n(4);
   endtask
   task automatic set_enable(input logic v);
      enable = v;
   endtask
   task automatic start(input logic [1:0] mode);
      set_reset(1'b0);
      {mode_select_2, mode_select_1} = mode;
      enable = 1'b1;
      set_reset(1'b1);
   endtask
   task automatic step(input logic dir);
      rotation_direction = dir;
      wait_n(1);
      step_pulse_in = 1'b1;
      wait_n(2);
      step_pulse_in = 1'b0;
      wait_n(3);
   endtask
   task automatic release_high();
      step_pulse_in = 1'b1;
      set_reset(1'b1);
      step_pulse_in = 1'b0;
      wait_n(3);
   endtask
   task automatic rehome();
      set_reset(1'b0);
      set_reset(1'b1);
   endtask
   task automatic clear_fault();
      enable = 1'b0;
      wait_n(EN_LOW_CYC);
      enable = 1'b1;
      wait_n(4);
   endtask
endmodule // host_model

// >>> sim/tb.sv
// Self-checking testbench of the micro-step sequencer and chopper
`timescale 1ns/1ps
module tb;
   localparam int OSC = 8;
   localparam int BLANK = 4;
   localparam int DEAD = 3;
   localparam int SENSE = 2;
   localparam int LIMIT = 40000;
   logic clock, rst_n, sleep_input, over_temp_trip;
   logic [7:0] over_current_trip;
   logic [1:0] supply_low_lock, current_reached_point;
   logic step_pulse_in, rotation_direction, mode_select_1, mode_select_2, enable, seq_reset_n;
   logic [1:0] high_side_left, high_side_right, low_side_left, low_side_right;
   logic [6:0] level_a, level_b;
   logic reverse_a, reverse_b, home_flag_n_out, home_flag_n_oe_n, over_current_latched;
   logic outputs_active;
   logic [7:0] gates;
   logic [6:0] tbl [17];
   int n_errors, compares;
   int cycles = 0;
   assign gates = {high_side_left, high_side_right, low_side_left, low_side_right};
   host_model host_u (.clock(clock), .step_pulse_in(step_pulse_in),
      .rotation_direction(rotation_direction), .mode_select_1(mode_select_1),
      .mode_select_2(mode_select_2), .enable(enable), .seq_reset_n(seq_reset_n));
   microstep_sequencer_chopper #(.OSC_DIV(OSC), .BLANK_CYC(BLANK), .DEAD_CYC(DEAD),
      .SENSE_CYC(SENSE)) dut_u (.clock(clock), .rst_n(rst_n), .step_pulse_in(step_pulse_in),
      .rotation_direction(rotation_direction), .mode_select_1(mode_select_1),
      .mode_select_2(mode_select_2), .enable(enable), .seq_reset_n(seq_reset_n),
      .sleep_input(sleep_input), .over_temp_trip(over_temp_trip),
      .over_current_trip(over_current_trip), .supply_low_lock(supply_low_lock),
      .current_reached_point(current_reached_point), .high_side_left(high_side_left),
      .high_side_right(high_side_right), .low_side_left(low_side_left),
      .low_side_right(low_side_right), .level_a(level_a), .level_b(level_b),
      .reverse_a(reverse_a), .reverse_b(reverse_b), .home_flag_n_out(home_flag_n_out),
      .home_flag_n_oe_n(home_flag_n_oe_n), .over_current_latched(over_current_latched),
      .outputs_active(outputs_active));
   // ----------------------------------------------------------------
   // Shared checks
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [6:0] mag(input int p);
      return (p & 16) ? tbl[16 - (p & 15)] : tbl[p & 15];
   endfunction
   task automatic check_pos(input int p);
      check("level_a", {1'b0, level_a}, {1'b0, mag(p)});
      check("level_b", {1'b0, level_b}, {1'b0, mag((p + 48) % 64)});
      check("home", {7'h00, home_flag_n_oe_n}, {7'h00, p != 0});
      if (mag(p) != 7'h00) check("rev_a", {7'h00, reverse_a}, {7'h00, p > 16 && p < 48});
      if (mag((p + 48) % 64) != 7'h00) check("rev_b", {7'h00, reverse_b}, {7'h00, p > 32});
   endtask
   task automatic complete_run();
      if (n_errors == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic reset_values();
      check("level_a", {1'b0, level_a}, 8'h64);
      check("level_b", {1'b0, level_b}, 8'h00);
      check("home_out", {7'h00, home_flag_n_out}, 8'h00);
      check("home_oe", {7'h00, home_flag_n_oe_n}, 8'h00);
      check("gates", gates, 8'h00);
   endtask
   task automatic walk_modes();
      int p;
      int strides [4] = '{1, 8, 4, 2};
      for (int m = 0; m < 4; m++) begin
         host_u.start(m[1:0]);
         p = 0;
         check_pos(p);
         for (int s = 0; s < 64 / strides[m] + 1; s++) begin
            host_u.step(1'b0);
            p = (p + strides[m]) % 64;
            check_pos(p);
         end
         for (int s = 0; s < 3; s++) begin
            host_u.step(1'b1);
            p = (p + 64 - strides[m]) % 64;
            check_pos(p);
         end
      end
   endtask
   task automatic reset_hold();
      host_u.start(2'h0);
      host_u.step(1'b0);
      host_u.step(1'b0);
      check_pos(2);
      host_u.set_reset(1'b0);
      host_u.step(1'b0);
      check_pos(0);
      check("active", {7'h00, outputs_active}, 8'h01);
      host_u.release_high();
      check_pos(1);
   endtask
   task automatic apply_off(input int k, input logic v);
      case (k)
         0: host_u.set_enable(!v);
         1: sleep_input = !v;
         2: over_temp_trip = v;
         default: supply_low_lock = v ? 2'(k - 2) : 2'h0;
      endcase
      host_u.wait_n(3);
   endtask
   task automatic standby();
      int p;
      p = 1;
      for (int k = 0; k < 5; k++) begin
         apply_off(k, 1'b1);
         host_u.step(1'b0);
         p = p + 1;
         check("gates_off", gates, 8'h00);
         check("active", {7'h00, outputs_active}, 8'h00);
         check_pos(p);
         apply_off(k, 1'b0);
         check("active", {7'h00, outputs_active}, 8'h01);
         check_pos(p);
      end
      host_u.rehome();
      check_pos(0);
   endtask
   task automatic over_current();
      for (int b = 0; b < 8; b++) begin
         over_current_trip = 8'h01 << b;
         host_u.wait_n(BLANK - 1);
         over_current_trip = 8'h00;
         host_u.wait_n(3);
         check("oc_short", {7'h00, over_current_latched}, 8'h00);
         over_current_trip = 8'h01 << b;
         host_u.wait_n(BLANK + 2);
         over_current_trip = 8'h00;
         host_u.wait_n(8);
         check("oc_latch", {7'h00, over_current_latched}, 8'h01);
         check("oc_gates", gates, 8'h00);
         if (b == 7) begin
            host_u.clear_fault();
         end else begin
            supply_low_lock = 2'(b % 2 + 1);
            host_u.wait_n(3);
            supply_low_lock = 2'h0;
            host_u.wait_n(3);
         end
         check("oc_clear", {7'h00, over_current_latched}, 8'h00);
      end
   endtask
   task automatic chop_run(input int ph, input logic [3:0] chg, input logic [3:0] fst,
      input logic hit);
      int last_fall, last_fast, n_chg, n_slow, n_fast, run, bad;
      logic [3:0] g, prev;
      last_fall = -100;
      last_fast = -1;
      n_chg = 0;
      n_slow = 0;
      n_fast = 0;
      run = 0;
      bad = 0;
      current_reached_point = {hit, hit};
      host_u.wait_n(8 * OSC);
      prev = {gates[6 + ph], gates[4 + ph], gates[2 + ph], gates[ph]};
      for (int t = 0; t < 32 * OSC; t++) begin
         host_u.wait_n(1);
         g = {gates[6 + ph], gates[4 + ph], gates[2 + ph], gates[ph]};
         if ((prev & ~g) != 4'h0) last_fall = t;
         if ((g & ~prev) != 4'h0 && t - last_fall < DEAD) bad++;
         if (g == chg) n_chg++;
         if (g == 4'h3) n_slow++;
         run = (g == fst) ? run + 1 : 0;
         if (run > OSC) bad++;
         if (g == fst && prev != fst) begin
            if (last_fast >= 0 && t - last_fast != 8 * OSC) bad++;
            last_fast = t;
            n_fast++;
         end
         prev = g;
      end
      check("chop_bad", bad[7:0], 8'h00);
      check("fast_seen", {7'h00, n_fast > 2}, 8'h01);
      check("charge", {7'h00, n_chg > 0 && (!hit || n_chg <= 5 * (SENSE + 2))}, 8'h01);
      check("slow", {7'h00, !hit || n_slow > 0}, 8'h01);
   endtask
   task automatic chopper();
      host_u.start(2'h0);
      chop_run(0, 4'h9, 4'h6, 1'b0);
      chop_run(0, 4'h9, 4'h6, 1'b1);
      for (int s = 0; s < 8; s++) host_u.step(1'b0);
      check_pos(8);
      chop_run(1, 4'h9, 4'h6, 1'b1);
      for (int s = 0; s < 24; s++) host_u.step(1'b0);
      check_pos(32);
      chop_run(0, 4'h6, 4'h9, 1'b0);
      chop_run(0, 4'h6, 4'h9, 1'b1);
      current_reached_point = 2'h0;
   endtask
   task automatic mid_reset();
      rst_n = 1'b0;
      host_u.wait_n(2);
      rst_n = 1'b1;
      host_u.wait_n(2);
      check("gates_dead", gates, 8'h00);
      check_pos(0);
   endtask
   // ----------------------------------------------------------------
   // Clock, sequence and timeout
   // ----------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   initial begin
      tbl = '{7'h64, 7'h64, 7'h62, 7'h60, 7'h5c, 7'h58, 7'h53, 7'h4d, 7'h47,
              7'h3f, 7'h38, 7'h2f, 7'h26, 7'h1d, 7'h14, 7'h0a, 7'h00};
      rst_n = 1'b0;
      sleep_input = 1'b1;
      over_temp_trip = 1'b0;
      over_current_trip = 8'h00;
      supply_low_lock = 2'h0;
      current_reached_point = 2'h0;
      n_errors = 0;
      compares = 0;
      repeat (12) @(negedge clock);
      rst_n = 1'b1;
      host_u.wait_n(2);
      reset_values();
      walk_modes();
      reset_hold();
      standby();
      over_current();
      chopper();
      mid_reset();
      complete_run();
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == LIMIT) begin
         n_errors++;
         complete_run();
      end
   end
endmodule // tb
